//--- verilog/ccu_consts.vh
`ifndef CCU_CONSTS_VH
`define CCU_CONSTS_VH
// Register indices as printed; byte address is four times the index
`define CCU_IDX_VALUE_LOW   8'h15
`define CCU_IDX_VALUE_HIGH  8'h16
`define CCU_IDX_CONTROL     8'h17
`define CCU_IDX_FLAGS       8'h18
`define CCU_ADDR_VALUE_LOW  12'h054
`define CCU_ADDR_VALUE_HIGH 12'h058
`define CCU_ADDR_CONTROL    12'h05C
`define CCU_ADDR_FLAGS      12'h060
`define CCU_CONTROL_RESET   6'h00
// Control fields
`define CCU_MODE_MSB        3
`define CCU_DUTY_LSB_ONE    5
`define CCU_DUTY_LSB_ZERO   4
// Flag register bit positions
`define CCU_FLAG_EVENT_BIT  2
`define CCU_FLAG_OVF_BIT    0
// Mode codes
`define CCU_MODE_OFF        4'h0
`define CCU_MODE_CAP_FALL   4'h4
`define CCU_MODE_CAP_RISE   4'h5
`define CCU_MODE_CAP_RISE4  4'h6
`define CCU_MODE_CAP_RISE16 4'h7
`define CCU_MODE_CMP_SET    4'h8
`define CCU_MODE_CMP_CLR    4'h9
`define CCU_MODE_CMP_SOFT   4'hA
`define CCU_MODE_CMP_TRIG   4'hB
// Prescaler terminal counts
`define CCU_PRESC_DIV4_LAST  4'h3
`define CCU_PRESC_DIV16_LAST 4'hF
`endif

//--- verilog/ccu_top.v
// Operation
// - mode zero clears compare latch and prescaler
// - 0100 falling, 0101 rising edge capture
// - 0110 every fourth, 0111 sixteenth rise
// - 1000 pin high, 1001 pin low, flag
// - 1010 flag only, pin unchanged
// - 1011 flag, timer reset, conversion start
// - 11xx is PWM; duty LSBs bits 5:4
// - capture copies 16-bit timer count
// - capture sets event flag until cleared
// - new capture overwrites unread value
// - port write on output pin captures
// - mode change may set flag falsely
// - prescaler cleared when off or non-capture
// - prescale mode change keeps prescaler count
// - compare on match entry only, action and flag
// - control zero forces compare latch low
// - trigger clears both timer count bytes
// - trigger reset never sets overflow flag
// - timer write beats trigger reset
`timescale 1ns/1ps
`include "ccu_consts.vh"
module ccu_top (
  // Clock and reset
  input  wire        I_CLK,
  input  wire        I_RESETN,
  // APB slave
  input  wire        I_PSEL,
  input  wire        I_PENABLE,
  input  wire        I_PWRITE,
  input  wire [11:0] I_PADDR,
  input  wire [31:0] I_PWDATA,
  output wire        O_PREADY,
  output reg  [31:0] O_PRDATA,
  output wire        O_PSLVERR,
  // Timer one interface
  input  wire [15:0] I_TIMER_COUNT,
  input  wire        I_TIMER_WRITE,
  input  wire        I_AD_ENABLE,
  output reg         O_TIMER_RESET,
  output reg         O_AD_START,
  // Unit pin
  input  wire        I_UNIT_PIN,
  input  wire        I_PORT_C_DIRECTION,
  input  wire        I_PORT_DATA,
  output reg         O_COMPARE_LATCH,
  output wire        O_UNIT_PIN,
  output wire        O_UNIT_PIN_OE,
  // Status
  output wire        O_EVENT_FLAG,
  output wire [1:0]  O_DUTY_LSB,
  output wire        O_PWM_MODE
);

  reg         rst_meta;
  reg         rst_n;
  reg  [7:0]  value_low;
  reg  [7:0]  value_high;
  reg  [5:0]  control;
  reg         event_flag;
  reg         pin_meta;
  reg         pin_sync;
  reg         pin_prev;
  reg  [3:0]  presc;
  reg         capture_event;
  reg         compare_hit;
  reg         next_latch;
  wire [3:0]  mode_select;
  wire        is_capture;
  wire        is_compare;
  wire        pin_level;
  wire        rise;
  wire        fall;
  wire        match;
  wire        wr_en;
  wire        rd_en;

  function sel;
    input [11:0] addr;
    input [11:0] want;
    begin
      sel = (addr == want);
    end
  endfunction

  // Reset release through two flops
  always @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  assign mode_select = control[`CCU_MODE_MSB:0];
  assign is_capture  = (mode_select[3:2] == 2'b01);
  assign is_compare  = (mode_select[3:2] == 2'b10);
  assign O_PWM_MODE  = (mode_select[3:2] == 2'b11);
  assign O_DUTY_LSB  = {control[`CCU_DUTY_LSB_ONE], control[`CCU_DUTY_LSB_ZERO]};
  assign O_EVENT_FLAG = event_flag;

  // APB: zero wait states, unmapped reads zero, no error
  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = 1'b0;
  assign wr_en = I_PSEL & I_PENABLE & I_PWRITE;
  assign rd_en = I_PSEL & ~I_PWRITE;

  // Pin seen through the port output when the pin drives
  assign pin_level = I_PORT_C_DIRECTION ? I_UNIT_PIN : I_PORT_DATA;
  assign O_UNIT_PIN    = O_PWM_MODE ? 1'b0 : O_COMPARE_LATCH;
  assign O_UNIT_PIN_OE = ~I_PORT_C_DIRECTION & (is_compare | O_PWM_MODE);

  // Synchronizer and edge detect
  always @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      pin_meta <= pin_level;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end
  assign rise = pin_sync & ~pin_prev;
  assign fall = ~pin_sync & pin_prev;

  // Capture event decode with prescaler
  always @* begin
    capture_event = 1'b0;
    case (mode_select)
      `CCU_MODE_CAP_FALL:   capture_event = fall;
      `CCU_MODE_CAP_RISE:   capture_event = rise;
      `CCU_MODE_CAP_RISE4:  capture_event = rise & (presc[1:0] == `CCU_PRESC_DIV4_LAST);
      `CCU_MODE_CAP_RISE16: capture_event = rise & (presc == `CCU_PRESC_DIV16_LAST);
      default:              capture_event = 1'b0;
    endcase
  end

  // Counter kept across prescale switches, cleared only outside capture
  always @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      presc <= 4'h0;
    end else if (!is_capture) begin
      presc <= 4'h0;
    end else if (rise) begin
      presc <= presc + 4'h1;
    end
  end

  assign match = is_compare & ({value_high, value_low} == I_TIMER_COUNT);

  // Compare fires once per match entry
  reg match_prev;
  always @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      match_prev <= 1'b0;
    end else begin
      match_prev <= match;
    end
  end
  always @* begin
    compare_hit = match & ~match_prev;
  end

  // Compare output latch
  always @* begin
    next_latch = O_COMPARE_LATCH;
    if (mode_select == `CCU_MODE_OFF) begin
      next_latch = 1'b0;
    end else if (compare_hit) begin
      case (mode_select)
        `CCU_MODE_CMP_SET: next_latch = 1'b1;
        `CCU_MODE_CMP_CLR: next_latch = 1'b0;
        default:           next_latch = O_COMPARE_LATCH;
      endcase
    end
  end

  always @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_COMPARE_LATCH <= 1'b0;
      O_TIMER_RESET   <= 1'b0;
      O_AD_START      <= 1'b0;
    end else begin
      O_COMPARE_LATCH <= next_latch;
      // Timer side writes win; the trigger never sets the overflow flag
      O_TIMER_RESET <= compare_hit & (mode_select == `CCU_MODE_CMP_TRIG)
                       & ~I_TIMER_WRITE;
      O_AD_START    <= compare_hit & (mode_select == `CCU_MODE_CMP_TRIG)
                       & I_AD_ENABLE;
    end
  end

  // Registers, capture and event flag
  always @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      value_low  <= 8'h00;
      value_high <= 8'h00;
      control    <= `CCU_CONTROL_RESET;
      event_flag <= 1'b0;
    end else begin
      if (wr_en && sel(I_PADDR, `CCU_ADDR_VALUE_LOW)) begin
        value_low <= I_PWDATA[7:0];
      end
      if (wr_en && sel(I_PADDR, `CCU_ADDR_VALUE_HIGH) && !O_PWM_MODE) begin
        value_high <= I_PWDATA[7:0];
      end
      if (wr_en && sel(I_PADDR, `CCU_ADDR_CONTROL)) begin
        control <= I_PWDATA[5:0];
      end
      if (capture_event) begin
        value_low  <= I_TIMER_COUNT[7:0];
        value_high <= I_TIMER_COUNT[15:8];
      end
      // Hardware set beats a software clear in the same cycle
      if (capture_event || compare_hit) begin
        event_flag <= 1'b1;
      end else if (wr_en && sel(I_PADDR, `CCU_ADDR_FLAGS)
                   && !I_PWDATA[`CCU_FLAG_EVENT_BIT]) begin
        event_flag <= 1'b0;
      end
    end
  end

  always @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_PRDATA <= 32'h00000000;
    end else if (rd_en && !I_PENABLE) begin
      O_PRDATA <= 32'h00000000;
      if (sel(I_PADDR, `CCU_ADDR_VALUE_LOW))  O_PRDATA[7:0] <= value_low;
      if (sel(I_PADDR, `CCU_ADDR_VALUE_HIGH)) O_PRDATA[7:0] <= value_high;
      if (sel(I_PADDR, `CCU_ADDR_CONTROL))    O_PRDATA[5:0] <= control;
      if (sel(I_PADDR, `CCU_ADDR_FLAGS))
        O_PRDATA[`CCU_FLAG_EVENT_BIT] <= event_flag;
    end
  end

endmodule

//--- verification/ccu_timer_model.sv
`timescale 1ns/1ps
module ccu_timer_model (
  // Control
  input  logic        clk,
  input  logic        run,
  input  logic        wr,
  input  logic [15:0] wval,
  input  logic        trig,
  // Count
  output logic [15:0] cnt
);
  initial cnt = 16'h0000;
  always @(posedge clk)
    if (wr) cnt <= wval;
    else if (trig) cnt <= 16'h0000;
    else if (run) cnt <= cnt + 16'h0001;
endmodule

//--- verification/ccu_checker.sv
`timescale 1ns/1ps
module ccu_checker (
  input logic        I_CLK,
  input logic        I_RESETN,
  input logic        I_PSEL,
  input logic        I_PENABLE,
  input logic        I_PWRITE,
  input logic [11:0] I_PADDR,
  input logic [31:0] I_PWDATA,
  input logic        I_TIMER_WRITE,
  input logic        I_AD_ENABLE,
  input logic        O_PREADY,
  input logic        O_PSLVERR,
  input logic        O_TIMER_RESET,
  input logic        O_AD_START,
  input logic        O_COMPARE_LATCH,
  input logic        O_EVENT_FLAG,
  input logic [1:0]  O_DUTY_LSB,
  input logic        O_PWM_MODE
);
  logic [5:0] ctl;
  wire wr = I_PSEL && I_PENABLE && I_PWRITE;
  wire fclr = wr && I_PADDR == 12'h060 && !I_PWDATA[2];
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN);
  always @(posedge I_CLK or negedge I_RESETN)
    if (!I_RESETN) ctl <= 6'h00;
    else if (wr && I_PADDR == 12'h05C) ctl <= I_PWDATA[5:0];
  sequence ctl_off_s;
    wr && I_PADDR == 12'h05C && I_PWDATA[5:0] == 6'h00;
  endsequence
  pulse_one_a: assert property ((O_TIMER_RESET || O_AD_START) |=> !O_TIMER_RESET)
    else $error("trigger pulse too long");
  trig_mode_a: assert property (O_TIMER_RESET |-> ctl[3:0] == 4'hB)
    else $error("timer reset outside trigger mode");
  write_wins_a: assert property ($past(I_TIMER_WRITE) |-> !O_TIMER_RESET)
    else $error("timer reset beat timer write");
  duty_bits_a: assert property (O_DUTY_LSB == ctl[5:4])
    else $error("duty bits differ from control");
  pwm_mode_a: assert property (O_PWM_MODE == (ctl[3:2] == 2'b11))
    else $error("pwm mode wrong");
  ad_start_a: assert property (O_TIMER_RESET && $past(I_AD_ENABLE) |-> O_AD_START)
    else $error("conversion start missing");
  off_quiet_a: assert property ((ctl == 6'h00) [*3] |-> !O_TIMER_RESET && !O_COMPARE_LATCH)
    else $error("unit active while off");
  latch_low_a: assert property (ctl_off_s |-> ##[1:2] !O_COMPARE_LATCH)
    else $error("latch not cleared");
  flag_keep_a: assert property (O_EVENT_FLAG && !fclr |=> O_EVENT_FLAG)
    else $error("event flag dropped");
  apb_ready_a: assert property (I_PSEL |-> O_PREADY && !O_PSLVERR)
    else $error("bus answer wrong");
  set_pin_a: assert property (ctl[3:0] == 4'h8 && $rose(O_EVENT_FLAG) |-> ##[0:2] O_COMPARE_LATCH)
    else $error("latch not set on match");
endmodule
bind ccu_top ccu_checker ccu_checker_inst (.*);

//--- verification/capture_compare_unit_tb.sv
`timescale 1ns/1ps
`include "ccu_consts.vh"
module capture_compare_unit_tb;
  localparam CT = `CCU_ADDR_CONTROL;
  localparam FL = `CCU_ADDR_FLAGS;
  logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, run = 0, twr = 0;
  logic        pin = 0, pready, pslverr, trst, adst, latch, pin_o, pin_oe, flag, pwm, pdat = 0;
  logic        dir = 1;
  logic [11:0] addr = 0;
  logic [31:0] wdata = 0, rdata, v;
  logic [15:0] tcnt, tval = 0;
  logic [1:0]  duty;
  logic [31:0] expq[$];
  integer      failures = 0, comparisons = 0, seed = 32'hecaaeeb0, i, n;
  always #2.5 clk = ~clk;
  ccu_top ccu_top_inst (.I_CLK(clk), .I_RESETN(rst_n), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(addr), .I_PWDATA(wdata),
    .O_PREADY(pready), .O_PRDATA(rdata), .O_PSLVERR(pslverr), .I_TIMER_COUNT(tcnt),
    .I_TIMER_WRITE(twr), .I_AD_ENABLE(1'b1), .O_TIMER_RESET(trst), .O_AD_START(adst),
    .I_UNIT_PIN(pin_oe ? pin_o : pin), .I_PORT_C_DIRECTION(dir), .I_PORT_DATA(pdat),
    .O_COMPARE_LATCH(latch), .O_UNIT_PIN(pin_o), .O_UNIT_PIN_OE(pin_oe),
    .O_EVENT_FLAG(flag), .O_DUTY_LSB(duty), .O_PWM_MODE(pwm));
  ccu_timer_model ccu_timer_model_inst (.clk(clk), .run(run), .wr(twr), .wval(tval),
    .trig(trst), .cnt(tcnt));
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] e);
    comparisons++;
    if (seen !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", s, e, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1;
    pwr <= w;
    addr <= a;
    wdata <= {24'h0, d};
    @(posedge clk) pen <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    expq.push_back({24'h0, e});
    apb(0, a, 8'h00);
  endtask
  always @(posedge clk)
    if (psel && pen && !pwr && pready) chk("read", rdata, expq.pop_front());
  task automatic settm(input logic [15:0] t);
    tval <= t;
    twr <= 1;
    @(posedge clk) twr <= 0;
  endtask
  task automatic pulse(input int k);
    repeat (k) begin
      pin <= ~pin;
      repeat (4) @(posedge clk);
      pin <= ~pin;
      repeat (4) @(posedge clk);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #50000;
    failures++;
    wrap_up;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    rd(CT, 8'h00);
    rd(12'h0FC, 8'h00);
    for (i = 4; i < 8; i++) begin
      n = (i == 6) ? 4 : (i == 7) ? 16 : 1;
      apb(1, CT, 8'h00);
      pin <= (i == 4);
      apb(1, CT, i[7:0]);
      apb(1, FL, 8'h00);
      pulse(n - 1);
      rd(FL, 8'h00);
      v = $random(seed);
      settm(~v[15:0]);
      pulse(1);
      settm(v[15:0]);
      pulse(n);
      rd(`CCU_ADDR_VALUE_LOW, v[7:0]);
      rd(`CCU_ADDR_VALUE_HIGH, v[15:8]);
      rd(FL, 8'h04);
      $display("capture mode %0d done", i);
    end
    dir <= 0;
    for (i = 8; i < 12; i++) begin
      apb(1, CT, 8'h00);
      @(posedge clk);
      chk("latch", {31'h0, latch}, 0);
      v = $random(seed) | 32'h8000;
      apb(1, `CCU_ADDR_VALUE_LOW, v[7:0]);
      apb(1, `CCU_ADDR_VALUE_HIGH, v[15:8]);
      apb(1, CT, i[7:0]);
      apb(1, FL, 8'h00);
      settm(v[15:0] - 16'h0006);
      run <= 1;
      repeat (12) @(posedge clk);
      run <= 0;
      chk("latch", {31'h0, latch}, {31'h0, i == 8});
      if (i == 11) chk("timer", {31'h0, tcnt < 16'h0010}, 1);
      rd(FL, 8'h04);
      $display("compare mode %0d done", i);
    end
    apb(1, CT, 8'h00);
    apb(1, CT, 8'h05);
    apb(1, FL, 8'h00);
    pdat <= 1;
    repeat (6) @(posedge clk);
    rd(FL, 8'h04);
    $display("port write capture done");
    apb(1, CT, 8'h3C);
    rd(CT, 8'h3C);
    chk("pwm", {29'h0, pwm, duty}, 7);
    wrap_up;
  end
endmodule
